// *** pkg/frc_pkg.sv ***
// Constants shared by the fine resolution counter and its strobe channels.
// Assumes byte addresses on an Avalon-MM slave with 32-bit data.
package frc_pkg;
  // Channel geometry
  localparam int NUM_CH = 4;
  localparam int SENSE_W = 3;
  localparam int ADDR_W = 8;
  localparam int PRESC_W = 15;
  localparam int TGT_W = 16;
  // Periodic alarm repeats every 60 prescaled units
  localparam logic [5:0] PER_LAST = 6'h3b;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_FINE = 8'h10;
  localparam logic [7:0] OFS_ALARM = 8'h14;
  localparam logic [7:0] OFS_ALARM_FINE = 8'h18;
  localparam logic [7:0] OFS_CAP_COUNT = 8'h1c;
  localparam logic [7:0] OFS_CAP_FINE = 8'h20;
  // Channel block: address[7:6] selects it, [5:4] the channel, [3:2] the register
  localparam logic [1:0] CH_BLOCK = 2'h1;
  localparam logic [1:0] CH_TARGET = 2'h0;
  localparam logic [1:0] CH_PERIOD = 2'h1;
  localparam logic [1:0] CH_WIDTH = 2'h2;
  localparam logic [1:0] CH_CFG = 2'h3;
  // Control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_SEL = 1;
  localparam int CTRL_EXP_LO = 4;
  localparam int CTRL_ALARM_EN = 8;
  localparam int CTRL_PER_EN = 9;
  localparam int CTRL_CAP_EN = 10;
  // Channel config fields
  localparam int CFG_EN = 0;
  localparam int CFG_MATCH_EN = 1;
  localparam int CFG_PAT_LO = 4;
  localparam int CFG_PMASK_LO = 8;
  localparam int CFG_SAMPLE_LO = 12;
  // Status layout: alarm, periodic, capture, activity per channel, match per channel
  localparam int ST_ALARM = 0;
  localparam int ST_PER = 1;
  localparam int ST_CAP = 2;
  localparam int ST_ACT_LO = 3;
  localparam int ST_MATCH_LO = 3 + NUM_CH;
  localparam int ST_W = 3 + 2 * NUM_CH;
  // Reset values
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [15:0] PERIOD_RST = 16'h0002;
  localparam logic [15:0] WIDTH_RST = 16'h0001;
endpackage

// *** logic/frc_sync.sv ***
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/10ps
module frc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;
  sync_s state;
  sync_s next_state;

  // The first stage feeds only the second stage
  always_comb begin
    next_state.meta = async_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;
endmodule

// *** logic/strobe_channel.sv ***
// One strobe channel: scheduled pulse output and sampling of its sense inputs.
// Assumes count_lo, tick and sense_in are already in the core_clk domain.
`timescale 1ns/10ps
module strobe_channel (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic [frc_pkg::TGT_W-1:0] count_lo,
  input wire logic load,
  input wire logic [frc_pkg::TGT_W-1:0] load_val,
  input wire logic [frc_pkg::TGT_W-1:0] period,
  input wire logic [frc_pkg::TGT_W-1:0] width,
  input wire logic enable,
  input wire logic match_en,
  input wire logic [frc_pkg::SENSE_W-1:0] pattern,
  input wire logic [frc_pkg::SENSE_W-1:0] pmask,
  input wire logic [frc_pkg::SENSE_W-1:0] sense_in,
  output logic strobe,
  output logic [frc_pkg::TGT_W-1:0] target,
  output logic [frc_pkg::SENSE_W-1:0] sample,
  output logic activity,
  output logic match
);
  typedef struct packed {
    logic [frc_pkg::TGT_W-1:0] target;
    logic [frc_pkg::TGT_W-1:0] wcnt;
    logic on;
    logic [frc_pkg::SENSE_W-1:0] sample;
    logic activity;
    logic match;
  } chan_s;
  chan_s state;
  chan_s next_state;

  // Pulse starts on a target hit, lasts width units, samples at its end
  always_comb begin
    next_state = state;
    next_state.activity = 1'b0;
    next_state.match = 1'b0;
    if (load) begin
      next_state.target = load_val;
    end else if (tick && enable) begin
      if (!state.on && count_lo == state.target) begin
        next_state.on = 1'b1;
        next_state.wcnt = '0;
        next_state.target = state.target + period;
      end else if (state.on) begin
        next_state.wcnt = state.wcnt + 16'h0001;
        // A width of zero still gives a one-unit pulse
        if (next_state.wcnt >= width) begin
          next_state.on = 1'b0;
          next_state.sample = sense_in;
          next_state.activity = (sense_in != state.sample);
          next_state.match = match_en && (((sense_in ^ pattern) & pmask) == '0);
        end
      end
    end
    if (!enable) begin
      next_state.on = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign strobe = state.on;
  assign target = state.target;
  assign sample = state.sample;
  assign activity = state.activity;
  assign match = state.match;
endmodule

// *** logic/fine_resolution_counter.sv ***
// Fine resolution real-time counter with alarms, strobe channels, capture and sense sampling.
// Assumes both low-frequency oscillators arrive as plain pins far slower than core_clk,
// and an Avalon-MM master that holds each request until waitrequest is low.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
// Functional notes
// - Absolute alarm compares count and fine prescaler, so it hits one low-freq cycle.
// - One absolute alarm, one periodic alarm every 60 prescaled units.
// - Four strobe channels, period and width programmable in prescaled units.
// - Strobe pulse starts when count reaches channel target; runs without CPU.
// - Transition on capture input snapshots the running count.
// - Capture sets a flag that drives interrupt and wake outputs.
// - Snapshot keeps fine prescaler so the exact low-freq cycle is known.
// - Each channel samples three sense inputs at end of its pulse.
// - Change of sampled sense inputs raises per-channel activity flag.
// - Sampled inputs equal to programmed pattern raise a match flag.
// - Counter prescaled by two to the power 0 to 15.
// - Low-freq source chosen between crystal and internal oscillator.
// - Interrupt when running count equals alarm value.
module fine_resolution_counter #(
  parameter int NUM_CH = frc_pkg::NUM_CH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic low_freq_crystal_osc,
  input wire logic low_freq_internal_osc,
  input wire logic capture_in,
  input wire logic [NUM_CH*frc_pkg::SENSE_W-1:0] sense_in,
  input wire logic [frc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [NUM_CH-1:0] strobe_out,
  output logic irq,
  output logic wake
);
  localparam int SW = frc_pkg::SENSE_W;
  localparam int IN_W = 3 + NUM_CH * SW;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic lf_prev;
    logic [frc_pkg::PRESC_W-1:0] prediv;
    logic [31:0] count;
    logic [5:0] per_cnt;
    logic cap_lf;
    logic [NUM_CH*SW-1:0] sense_lf;
    logic [10:0] ctrl;
    logic [31:0] alarm;
    logic [frc_pkg::PRESC_W-1:0] alarm_fine;
    logic [frc_pkg::ST_W-1:0] status;
    logic [frc_pkg::ST_W-1:0] mask;
    logic [31:0] cap_count;
    logic [frc_pkg::PRESC_W-1:0] cap_fine;
    logic [NUM_CH-1:0][15:0] period;
    logic [NUM_CH-1:0][15:0] width;
    logic [NUM_CH-1:0][10:0] cfg;
    logic [NUM_CH-1:0] load;
    logic [15:0] load_val;
  } top_s;
  top_s state;
  top_s next_state;

  logic [IN_W-1:0] in_sync;
  logic [NUM_CH-1:0][15:0] ch_target;
  logic [NUM_CH-1:0][SW-1:0] ch_sample;
  logic [NUM_CH-1:0] ch_act;
  logic [NUM_CH-1:0] ch_match;
  logic lf_sel;
  logic lf_tick;
  logic tick_p;
  logic [15:0] presc_mask;
  logic ev_alarm;
  logic ev_per;
  logic ev_cap;
  logic [frc_pkg::ST_W-1:0] set_bits;
  logic [31:0] rd_mux;
  logic [31:0] wr_word;
  logic [1:0] ch_sel;

  // Oscillator pins, capture pin and sense pins all cross from outside
  frc_sync #(
    .WIDTH(IN_W)
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({sense_in, capture_in, low_freq_internal_osc, low_freq_crystal_osc}),
    .sync_out(in_sync)
  );

  // Strobe channels share the prescaled tick and the low count bits
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    strobe_channel u_ch (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .tick(tick_p),
      .count_lo(state.count[15:0]),
      .load(state.load[c]),
      .load_val(state.load_val),
      .period(state.period[c]),
      .width(state.width[c]),
      .enable(state.cfg[c][frc_pkg::CFG_EN]),
      .match_en(state.cfg[c][frc_pkg::CFG_MATCH_EN]),
      .pattern(state.cfg[c][frc_pkg::CFG_PAT_LO +: SW]),
      .pmask(state.cfg[c][frc_pkg::CFG_PMASK_LO +: SW]),
      .sense_in(state.sense_lf[c*SW +: SW]),
      .strobe(strobe_out[c]),
      .target(ch_target[c]),
      .sample(ch_sample[c]),
      .activity(ch_act[c]),
      .match(ch_match[c])
    );
  end

  // Merge write data under byte enables
  function automatic logic [31:0] merge_be(input logic [31:0] old_val, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Time base: clock select, edge detect on the synchronised oscillator, prescaler
  always_comb begin
    lf_sel = state.ctrl[frc_pkg::CTRL_SEL] ? in_sync[1] : in_sync[0];
    lf_tick = lf_sel & ~state.lf_prev;
    presc_mask = (16'h0001 << state.ctrl[frc_pkg::CTRL_EXP_LO +: 4]) - 16'h0001;
    // At or above the mask, so lowering the exponent never strands the prescaler above it
    tick_p = lf_tick & state.ctrl[frc_pkg::CTRL_EN] & (state.prediv >= presc_mask[14:0]);
    ev_alarm = lf_tick & state.ctrl[frc_pkg::CTRL_EN] & state.ctrl[frc_pkg::CTRL_ALARM_EN]
               & (state.count == state.alarm) & (state.prediv == state.alarm_fine);
    ev_per = tick_p & state.ctrl[frc_pkg::CTRL_PER_EN] & (state.per_cnt == frc_pkg::PER_LAST);
    // Compare new low-freq sample with the last one, so edges are counted per lf cycle
    ev_cap = lf_tick & state.ctrl[frc_pkg::CTRL_CAP_EN] & (in_sync[2] != state.cap_lf);
    set_bits = '0;
    set_bits[frc_pkg::ST_ALARM] = ev_alarm;
    set_bits[frc_pkg::ST_PER] = ev_per;
    set_bits[frc_pkg::ST_CAP] = ev_cap;
    set_bits[frc_pkg::ST_ACT_LO +: NUM_CH] = ch_act;
    set_bits[frc_pkg::ST_MATCH_LO +: NUM_CH] = ch_match;
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    rd_mux = '0;
    ch_sel = address[5:4];
    if (address[7:6] == frc_pkg::CH_BLOCK) begin
      case (address[3:2])
        frc_pkg::CH_TARGET: rd_mux[15:0] = ch_target[ch_sel];
        frc_pkg::CH_PERIOD: rd_mux[15:0] = state.period[ch_sel];
        frc_pkg::CH_WIDTH: rd_mux[15:0] = state.width[ch_sel];
        default: begin
          rd_mux[10:0] = state.cfg[ch_sel];
          rd_mux[frc_pkg::CFG_SAMPLE_LO +: SW] = ch_sample[ch_sel];
        end
      endcase
    end else begin
      case (address)
        frc_pkg::OFS_CTRL: rd_mux[10:0] = state.ctrl;
        frc_pkg::OFS_STATUS: rd_mux[frc_pkg::ST_W-1:0] = state.status;
        frc_pkg::OFS_MASK: rd_mux[frc_pkg::ST_W-1:0] = state.mask;
        frc_pkg::OFS_COUNT: rd_mux = state.count;
        frc_pkg::OFS_FINE: rd_mux[14:0] = state.prediv;
        frc_pkg::OFS_ALARM: rd_mux = state.alarm;
        frc_pkg::OFS_ALARM_FINE: rd_mux[14:0] = state.alarm_fine;
        frc_pkg::OFS_CAP_COUNT: rd_mux = state.cap_count;
        frc_pkg::OFS_CAP_FINE: rd_mux[14:0] = state.cap_fine;
        default: rd_mux = '0;
      endcase
    end
  end

  // Next state: counting, capture, sticky flags and register writes
  always_comb begin
    next_state = state;
    next_state.lf_prev = lf_sel;
    next_state.load = '0;
    wr_word = '0;
    // Counter only advances on a low-freq edge, prescaled by the power-of-two mask
    if (lf_tick && state.ctrl[frc_pkg::CTRL_EN]) begin
      if (tick_p) begin
        next_state.prediv = '0;
        next_state.count = state.count + 32'h0000_0001;
        next_state.per_cnt = (state.per_cnt == frc_pkg::PER_LAST) ? 6'h00 : state.per_cnt + 6'h01;
      end else begin
        next_state.prediv = state.prediv + 15'h0001;
      end
    end
    // External levels are only looked at once per low-freq cycle
    if (lf_tick) begin
      next_state.cap_lf = in_sync[2];
      next_state.sense_lf = in_sync[IN_W-1:3];
    end
    if (ev_cap) begin
      next_state.cap_count = state.count;
      next_state.cap_fine = state.prediv;
    end
    // Bus: one wait cycle, then answer; read data registered in the wait cycle
    next_state.ack = (read | write) & ~state.ack;
    if (read && !state.ack) begin
      next_state.rdata = rd_mux;
    end
    // Set wins over a simultaneous write-one clear
    next_state.status = state.status | set_bits;
    if (write && state.ack) begin
      if (address[7:6] == frc_pkg::CH_BLOCK) begin
        case (address[3:2])
          frc_pkg::CH_TARGET: begin
            wr_word = merge_be({16'h0000, ch_target[ch_sel]}, writedata, byteenable);
            next_state.load[ch_sel] = 1'b1;
            next_state.load_val = wr_word[15:0];
          end
          frc_pkg::CH_PERIOD: begin
            wr_word = merge_be({16'h0000, state.period[ch_sel]}, writedata, byteenable);
            next_state.period[ch_sel] = wr_word[15:0];
          end
          frc_pkg::CH_WIDTH: begin
            wr_word = merge_be({16'h0000, state.width[ch_sel]}, writedata, byteenable);
            next_state.width[ch_sel] = wr_word[15:0];
          end
          default: begin
            wr_word = merge_be({21'h000000, state.cfg[ch_sel]}, writedata, byteenable);
            next_state.cfg[ch_sel] = wr_word[10:0];
          end
        endcase
      end else begin
        case (address)
          frc_pkg::OFS_CTRL: begin
            wr_word = merge_be({21'h000000, state.ctrl}, writedata, byteenable);
            next_state.ctrl = wr_word[10:0];
          end
          frc_pkg::OFS_STATUS: begin
            wr_word = merge_be(32'h0000_0000, writedata, byteenable);
            next_state.status = (state.status & ~wr_word[frc_pkg::ST_W-1:0]) | set_bits;
          end
          frc_pkg::OFS_MASK: begin
            wr_word = merge_be({21'h000000, state.mask}, writedata, byteenable);
            next_state.mask = wr_word[frc_pkg::ST_W-1:0];
          end
          frc_pkg::OFS_ALARM: begin
            next_state.alarm = merge_be(state.alarm, writedata, byteenable);
          end
          frc_pkg::OFS_ALARM_FINE: begin
            wr_word = merge_be({17'h00000, state.alarm_fine}, writedata, byteenable);
            next_state.alarm_fine = wr_word[14:0];
          end
          default: begin
            wr_word = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
      state.ctrl <= frc_pkg::CTRL_RST;
      for (int c = 0; c < NUM_CH; c++) begin
        state.period[c] <= frc_pkg::PERIOD_RST;
        state.width[c] <= frc_pkg::WIDTH_RST;
      end
    end else begin
      state <= next_state;
    end
  end

  // Outputs; wake follows irq so any enabled flag leaves low power
  assign readdata = state.rdata;
  assign waitrequest = ~state.ack;
  assign irq = |(state.status & state.mask);
  assign wake = irq;
endmodule

// *** tb/frc_checker.sv ***
// Checker on the counter's ports: bus handshake, interrupt outputs and strobe pulses.
// Assumes it is bound into the top module and sees nothing but its ports.
`timescale 1ns/10ps
module frc_checker #(
  parameter int NUM_CH = 4
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [frc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [NUM_CH-1:0] strobe_out,
  input wire logic irq,
  input wire logic wake
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Bus steps: request taken in its first cycle, then an answer standing one cycle
  sequence s_take;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  property p_answer;
    s_take |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer is not one wait state");
  property p_idle;
    !read && !write |-> waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest low while idle");
  // Read data must not drift between reads, software may fetch it late
  property p_hold_rdata;
    !read |=> $stable(readdata);
  endproperty
  a_hold_rdata: assert property (p_hold_rdata) else $error("readdata changed without a read");
  property p_unmapped;
    read && !waitrequest && address == 8'h24 |-> readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_wake;
    wake == irq;
  endproperty
  a_wake: assert property (p_wake) else $error("wake differs from irq");
  property p_mask_off;
    write && !waitrequest && address == frc_pkg::OFS_MASK && byteenable[1:0] == 2'h3
      && writedata[10:0] == 11'h0 |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq high with all masks clear");
  property p_strobe;
    $rose(strobe_out[0]) |=> strobe_out[0];
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe shorter than one tick");
  property p_quiet;
    $rose(reset_n) |-> !irq && strobe_out == '0 && waitrequest;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs not quiet after reset");
endmodule

bind fine_resolution_counter frc_checker #(.NUM_CH(NUM_CH)) chk_i (.core_clk(core_clk), .reset_n(reset_n),
  .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .strobe_out(strobe_out), .irq(irq), .wake(wake));

// *** tb/sensor_model.sv ***
// External sensor: answers each strobe with status levels and toggles its event pin.
// Assumes the response delay stays shorter than the programmed strobe width.
`timescale 1ns/10ps
module sensor_model (
  input wire logic core_clk,
  input wire logic [3:0] strobe_out,
  input wire logic [11:0] resp,
  input wire logic [7:0] delay,
  input wire logic kick,
  output logic [11:0] sense_in,
  output logic capture_in
);
  initial begin
    sense_in = 12'h0;
    capture_in = 1'b0;
  end
  // A slow sensor settles its status some cycles after the pulse starts
  for (genvar c = 0; c < 4; c++) begin : g_ch
    always @(posedge strobe_out[c]) begin
      repeat (delay) @(posedge core_clk);
      sense_in[3*c +: 3] <= resp[3*c +: 3];
    end
  end
  // Each request is one transition, either direction
  always @(posedge kick) capture_in <= ~capture_in;
endmodule

// *** tb/fine_resolution_counter_test.sv ***
// Self-checking bench for the counter: registers, time base, alarms, capture and strobes.
// Assumes the sensor model on the sense and capture pins; low-frequency clocks run fast.
`timescale 1ns/10ps
module fine_resolution_counter_test;
  logic core_clk, reset_n, xtal, iosc, capture_in, read, write, irq, wake, waitrequest, kick;
  logic [11:0] sense_in, resp;
  logic [7:0] address, delay;
  logic [31:0] writedata, readdata, q, a, b;
  logic [3:0] strobe_out;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  fine_resolution_counter dut (.core_clk(core_clk), .reset_n(reset_n), .low_freq_crystal_osc(xtal),
    .low_freq_internal_osc(iosc), .capture_in(capture_in), .sense_in(sense_in), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
    .waitrequest(waitrequest), .strobe_out(strobe_out), .irq(irq), .wake(wake));
  sensor_model sensor (.core_clk(core_clk), .strobe_out(strobe_out), .resp(resp), .delay(delay),
    .kick(kick), .sense_in(sense_in), .capture_in(capture_in));

  // Core clock; low-frequency sources at 16 and 24 core cycles, unrelated in phase
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    xtal = 1'b0;
    #7;
    forever #40 xtal = ~xtal;
  end
  initial begin
    iosc = 1'b0;
    #3;
    forever #60 iosc = ~iosc;
  end

  // Cycle count doubles as time stamp and hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr_en, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    address <= ad;
    writedata <= d;
    write <= wr_en;
    read <= !wr_en;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, ad, d, r);
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] r);
    bus(1'b0, ad, 32'h0, r);
  endtask

  function automatic logic [7:0] chad(input int c, input logic [1:0] r);
    return {frc_pkg::CH_BLOCK, 2'(c), r, 2'h0};
  endfunction

  // Interrupt sampled mid-cycle so the edge's updates have landed
  task automatic chk_irq(input logic e);
    @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // Looks mid-cycle, so a flag cleared by the write just before is not seen stale
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    @(negedge core_clk);
    while (irq !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask

  task automatic t_reset_vals();
    rd(frc_pkg::OFS_CTRL, q);
    chk(q, 32'h0);
    rd(frc_pkg::OFS_STATUS, q);
    chk(q, 32'h0);
    rd(frc_pkg::OFS_MASK, q);
    chk(q, 32'h0);
    rd(chad(3, frc_pkg::CH_PERIOD), q);
    chk(q, 32'h2);
    rd(chad(3, frc_pkg::CH_WIDTH), q);
    chk(q, 32'h1);
    rd(8'h24, q);
    chk(q, 32'h0);
    chk_irq(1'b0);
  endtask

  // Count advance over 960 cycles for each source, prescale edge and disabled counter
  task automatic t_rate();
    logic [31:0] ctl [5] = '{32'h1, 32'h3, 32'h21, 32'hf1, 32'h0};
    int exp_d [5] = '{60, 40, 15, 0, 0};
    int d;
    for (int i = 0; i < 5; i++) begin
      wr(frc_pkg::OFS_CTRL, ctl[i]);
      rd(frc_pkg::OFS_COUNT, a);
      repeat (960) @(posedge core_clk);
      rd(frc_pkg::OFS_COUNT, b);
      d = int'(b - a) - exp_d[i];
      chk((d <= 1 && d >= -1) ? 32'h1 : 32'h0, 32'h1);
    end
  endtask

  task automatic t_alarm();
    wr(frc_pkg::OFS_CTRL, 32'h31);
    rd(frc_pkg::OFS_COUNT, a);
    wr(frc_pkg::OFS_ALARM, a + 4);
    wr(frc_pkg::OFS_ALARM_FINE, 32'h5);
    wr(frc_pkg::OFS_MASK, 32'h1);
    wr(frc_pkg::OFS_STATUS, 32'h7ff);
    wr(frc_pkg::OFS_CTRL, 32'h131);
    wait_irq(1500);
    rd(frc_pkg::OFS_FINE, q);
    chk((q == 32'h5 || q == 32'h6) ? 32'h1 : 32'h0, 32'h1);
    rd(frc_pkg::OFS_COUNT, q);
    chk(q, a + 4);
    wr(frc_pkg::OFS_MASK, 32'h0);
    chk_irq(1'b0);
    wr(frc_pkg::OFS_MASK, 32'h1);
    chk_irq(1'b1);
    wr(frc_pkg::OFS_STATUS, 32'h1);
    chk_irq(1'b0);
  endtask

  task automatic t_periodic();
    wr(frc_pkg::OFS_CTRL, 32'h201);
    wr(frc_pkg::OFS_MASK, 32'h2);
    wr(frc_pkg::OFS_STATUS, 32'h7ff);
    wait_irq(2000);
    rd(frc_pkg::OFS_COUNT, a);
    wr(frc_pkg::OFS_STATUS, 32'h2);
    wait_irq(2000);
    rd(frc_pkg::OFS_COUNT, b);
    chk(b - a, 32'd60);
  endtask

  // Rising then falling event edge, each snapshotted
  task automatic t_capture();
    wr(frc_pkg::OFS_CTRL, 32'h401);
    wr(frc_pkg::OFS_MASK, 32'h4);
    for (int i = 0; i < 2; i++) begin
      wr(frc_pkg::OFS_STATUS, 32'h7ff);
      rd(frc_pkg::OFS_COUNT, a);
      kick <= 1'b1;
      @(posedge core_clk);
      kick <= 1'b0;
      wait_irq(200);
      chk({31'h0, wake}, 32'h1);
      rd(frc_pkg::OFS_CAP_COUNT, q);
      rd(frc_pkg::OFS_COUNT, b);
      chk((q >= a && q <= b) ? 32'h1 : 32'h0, 32'h1);
      rd(frc_pkg::OFS_CAP_FINE, q);
      chk(q, 32'h0);
    end
  endtask

  // All four channels pulse; channel 1 is given a pattern its sensor never sends
  task automatic t_strobe();
    int r0;
    logic [2:0] pat;
    wr(frc_pkg::OFS_CTRL, 32'h1);
    wr(frc_pkg::OFS_STATUS, 32'h7ff);
    wr(frc_pkg::OFS_MASK, 32'h780);
    rd(frc_pkg::OFS_COUNT, a);
    for (int c = 0; c < 4; c++) begin
      pat = (c == 1) ? ~resp[3*c +: 3] : resp[3*c +: 3];
      wr(chad(c, frc_pkg::CH_TARGET), a + 12 + c);
      wr(chad(c, frc_pkg::CH_PERIOD), 32'h6);
      wr(chad(c, frc_pkg::CH_WIDTH), 32'h2);
      wr(chad(c, frc_pkg::CH_CFG), {21'h0, 3'h7, 1'b0, pat, 4'h3});
    end
    while (strobe_out[0] !== 1'b1) @(posedge core_clk);
    r0 = cyc;
    while (strobe_out[0] === 1'b1) @(posedge core_clk);
    chk(32'(cyc - r0), 32'd32);
    rd(chad(0, frc_pkg::CH_TARGET), q);
    chk(q, a + 18);
    while (strobe_out[0] !== 1'b1) @(posedge core_clk);
    chk(32'(cyc - r0), 32'd96);
    while (strobe_out[0] === 1'b1) @(posedge core_clk);
    rd(frc_pkg::OFS_STATUS, q);
    chk(q & 32'h7f8, 32'h6f8);
    rd(chad(2, frc_pkg::CH_CFG), q);
    chk(q & 32'h7000, 32'h6000);
    chk({31'h0, wake}, 32'h1);
  endtask

  initial begin
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h0;
    writedata = 32'h0;
    kick = 1'b0;
    delay = 8'd10;
    resp = 12'hf9d;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset_vals();
    t_rate();
    t_alarm();
    t_periodic();
    t_capture();
    t_strobe();
    stop_test();
  end
endmodule
